// ### rtl/tomj_pkg.sv
/*
  Shared constants, types and slot decode for the third-order justifying
  multiplexer and demultiplexer. Assumes nothing beyond a SystemVerilog tool.
*/
package tomj_pkg;
  localparam int NTRIB = 4;
  localparam logic [9:0] SET_BITS = 10'h2cc;
  localparam logic [1:0] SET_FAW = 2'h0;
  localparam logic [1:0] SET_SVC = 2'h1;
  localparam logic [1:0] SET_JUST = 2'h2;
  localparam logic [11:0] FAW_WORD = 12'hfa0;
  localparam logic [9:0] FAW_LEN = 10'h00c;
  localparam logic [9:0] CTL_HI = 10'h004;
  localparam logic [9:0] SVC_A = 10'h005;
  localparam logic [9:0] SVC_B = 10'h006;
  localparam logic [9:0] RALM_BIT = 10'h007;
  localparam logic [9:0] RING_BIT = 10'h008;
  localparam logic [9:0] C2_LO = 10'h009;
  localparam logic [9:0] C2_HI = 10'h00c;
  localparam logic [9:0] NEG_LO = 10'h009;
  localparam logic [9:0] POS_LO = 10'h00d;
  localparam logic [9:0] POS_HI = 10'h010;
  localparam logic [1:0] ALIGN_LOSS_CNT = 2'h3;
  localparam logic [1:0] ALIGN_GAIN_CNT = 2'h3;
  localparam int SYS_PERIOD_NS = 10;
  localparam int LINK_PERIOD_NS = 160;
  localparam int LINK_DIV = LINK_PERIOD_NS / SYS_PERIOD_NS;
  localparam int TRIB_LOS_CYC = 200;
  localparam int LINE_LOS_BITS = 64;
  localparam logic [11:0] AIS_MAX_ZEROS = 12'h002;

  typedef enum logic [1:0] {j_none, j_pos, j_neg} tomj_just_type;
  typedef enum logic [3:0] {
    sl_data, sl_faw, sl_ctl, sl_svc, sl_ralm, sl_ring, sl_nat, sl_neg, sl_pos
  } tomj_slot_type;

  // role of a bit slot; b is the 1-based bit number inside its set
  function automatic tomj_slot_type tomj_slot(input logic [1:0] set, input logic [9:0] b);
    tomj_slot_type s;
    s = sl_data;
    if (set == SET_FAW && b <= FAW_LEN) begin
      s = sl_faw;
    end else if (set == SET_SVC) begin
      if (b <= CTL_HI || (b >= C2_LO && b <= C2_HI)) s = sl_ctl;
      else if (b == SVC_A || b == SVC_B) s = sl_svc;
      else if (b == RALM_BIT) s = sl_ralm;
      else if (b == RING_BIT) s = sl_ring;
    end else if (set == SET_JUST) begin
      if (b <= CTL_HI) s = sl_ctl;
      else if (b < NEG_LO) s = sl_nat;
      else if (b < POS_LO) s = sl_neg;
      else if (b <= POS_HI) s = sl_pos;
    end
    return s;
  endfunction

  function automatic logic tomj_maj(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction
endpackage

// ### rtl/tomj_link_if.sv
/*
  Composite link between the multiplexer end and the demultiplexer end.
  Assumes the multiplexer end drives both wires.
*/
`timescale 1ns/10ps
`default_nettype none
interface tomj_link_if;
  logic link_clk;
  logic link_data;
  modport mux_end(output link_clk, output link_data);
  modport demux_end(input link_clk, input link_data);
endinterface
`default_nettype wire

// ### rtl/tomj_sync.sv
/*
  Two-flop synchroniser for levels, W bits wide.
  Assumes each bit is an independent level; no word coherence.
*/
`timescale 1ns/10ps
`default_nettype none
module tomj_sync #(
  parameter int W = 1
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      q_o <= '0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ### rtl/tomj_mux.sv
/*
  Multiplexer end: interleaves four tributaries into the composite frame,
  sends justification commands and service bits, makes the link clock.
  Assumes tributary pins are asynchronous; command inputs are on clk_sys_i.
*/
`timescale 1ns/10ps
`default_nettype none
module tomj_mux
  import tomj_pkg::*;
#(
  parameter int DIV = LINK_DIV,
  parameter int LOS_CYC = TRIB_LOS_CYC
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  tomj_link_if.mux_end link,
  input wire logic [3:0] trib_data_i,
  input wire logic [3:0] trib_clk_i,
  input wire logic [7:0] just_cmd_i,
  input wire logic ext_clk_i,
  input wire logic ext_sel_i,
  input wire logic [1:0] svc_data_i,
  input wire logic svc_ring_i,
  input wire logic rem_alarm_i,
  output logic [3:0] trib_los_o,
  output logic prompt_o
);
  logic [3:0] tdat_s, tclk_s, tdat_prev_q, tclk_prev_q, tbit_q;
  logic ext_s, ext_prev_q, clk_q, out_q, rise, fall;
  logic [7:0] div_q;
  logic [7:0] dgap_q [NTRIB];
  logic [7:0] cgap_q [NTRIB];
  logic [1:0] set_q, nset, t;
  logic [9:0] bit_q, nbit;
  logic nfrm, pb, pair_b_q, ralm_q, ring_q, dv, nxt;
  logic [1:0] svc_q;
  logic [7:0] cmd_q;
  tomj_just_type cm;

  tomj_sync #(.W(9)) u_pin_sync (
    .clk_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i({ext_clk_i, trib_clk_i, trib_data_i}),
    .q_o({ext_s, tclk_s, tdat_s})
  );

  ////////////////////////////////////////////////////////////////////////
  // link clock: internal divider or slaved to the external timing edge
  assign rise = ext_sel_i ? (ext_s & ~ext_prev_q) : (div_q == 8'h00);
  assign fall = ext_sel_i ? (~ext_s & ext_prev_q) : (div_q == 8'(DIV / 2));

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_q <= 8'h00;
      ext_prev_q <= 1'b0;
      clk_q <= 1'b0;
    end else if (ce_i) begin
      div_q <= (div_q == 8'(DIV - 1)) ? 8'h00 : div_q + 8'h01;
      ext_prev_q <= ext_s;
      if (rise) clk_q <= 1'b1;
      else if (fall) clk_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tributary capture and loss detection on data or timing circuit
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      tdat_prev_q <= 4'h0;
      tclk_prev_q <= 4'h0;
      tbit_q <= 4'hf;
      trib_los_o <= 4'h0;
      prompt_o <= 1'b0;
      for (int i = 0; i < NTRIB; i++) begin
        dgap_q[i] <= 8'h00;
        cgap_q[i] <= 8'h00;
      end
    end else if (ce_i) begin
      tdat_prev_q <= tdat_s;
      tclk_prev_q <= tclk_s;
      for (int i = 0; i < NTRIB; i++) begin
        if (tclk_s[i] & ~tclk_prev_q[i]) tbit_q[i] <= tdat_s[i];
        if (tclk_s[i] != tclk_prev_q[i]) cgap_q[i] <= 8'h00;
        else if (cgap_q[i] != 8'(LOS_CYC)) cgap_q[i] <= cgap_q[i] + 8'h01;
        if (tdat_s[i] != tdat_prev_q[i]) dgap_q[i] <= 8'h00;
        else if (dgap_q[i] != 8'(LOS_CYC)) dgap_q[i] <= dgap_q[i] + 8'h01;
        // either circuit silent counts as loss
        trib_los_o[i] <= (cgap_q[i] == 8'(LOS_CYC)) | (dgap_q[i] == 8'(LOS_CYC));
      end
      prompt_o <= |trib_los_o;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // frame position and outgoing bit
  always_comb begin
    nfrm = (bit_q == SET_BITS) && (set_q == SET_JUST);
    nbit = (bit_q == SET_BITS) ? 10'h001 : bit_q + 10'h001;
    nset = set_q;
    if (bit_q == SET_BITS) nset = (set_q == SET_JUST) ? SET_FAW : set_q + 2'h1;
    pb = nfrm ? ~pair_b_q : pair_b_q;
    t = 2'(nbit - 10'h001); // ascending tributary order
    cm = tomj_just_type'(cmd_q[{t, 1'b0} +: 2]);
    dv = tbit_q[t] | trib_los_o[t]; // ones in a lost tributary's slots
    case (tomj_slot(nset, nbit))
      sl_faw: nxt = FAW_WORD[4'(FAW_LEN - nbit)];
      // first frame: 1 unless negative; second: 1 only for positive
      sl_ctl: nxt = pb ? (cm == j_pos) : (cm != j_neg);
      sl_svc: nxt = (nbit == SVC_A) ? svc_q[1] : svc_q[0];
      sl_ralm: nxt = ralm_q;
      sl_ring: nxt = ring_q;
      sl_nat: nxt = 1'b1;
      // idle negative slot tells whether positive justification is commanded
      sl_neg: nxt = (pb && cm == j_neg) ? dv : (cm == j_pos);
      sl_pos: nxt = (pb && cm == j_pos) ? 1'b0 : dv;
      default: nxt = dv;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      set_q <= SET_JUST;
      bit_q <= SET_BITS;
      pair_b_q <= 1'b1;
      cmd_q <= 8'h00;
      svc_q <= 2'h0;
      ring_q <= 1'b0;
      ralm_q <= 1'b0;
      out_q <= 1'b1;
    end else if (ce_i && fall && clk_q) begin
      // only a real falling link edge advances; a slaved source may start low
      set_q <= nset;
      bit_q <= nbit;
      out_q <= nxt;
      if (nfrm) begin
        pair_b_q <= ~pair_b_q;
        // command held over the whole pair
        if (pair_b_q) cmd_q <= just_cmd_i;
        svc_q <= svc_data_i;
        ring_q <= svc_ring_i;
        ralm_q <= rem_alarm_i;
      end
    end
  end

  assign link.link_clk = clk_q;
  assign link.link_data = out_q;
endmodule
`default_nettype wire

// ### rtl/tomj_demux.sv
/*
  Demultiplexer end: frame alignment, justification decode, tributary
  recovery, fault detection and consequent actions. Link logic runs on the
  incoming link clock; alarms cross to clk_sys_i through synchronisers.
  Assumes the far end changes link_data away from the rising link edge.
*/
`timescale 1ns/10ps
`default_nettype none
module tomj_demux
  import tomj_pkg::*;
#(
  parameter int LOS_BITS = LINE_LOS_BITS
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ce_i,
  tomj_link_if.demux_end link,
  output logic [3:0] trib_data_o,
  output logic [3:0] trib_stb_o,
  output logic [1:0] svc_data_o,
  output logic svc_ring_o,
  output logic prompt_o,
  output logic send_rai_o,
  output logic rem_alarm_o,
  output logic lof_o,
  output logic los_o
);
  typedef enum logic [1:0] {st_search, st_verify, st_sync} tomj_align_type;

  logic lclk, d, rst_l, ce_l;
  logic rst_m_q, rst_l_q;
  tomj_align_type st_q;
  logic [1:0] cnt_q, set_q, t;
  logic [9:0] bit_q;
  logic [11:0] sh_q, zcnt_q;
  logic [7:0] zrun_q;
  logic match, at_faw, wrap, los_l, ais_q, lof_l, force_l, rem_q;
  logic prompt_l, rai_l, pair_b_q, keep;
  logic [3:0] c1_q, c2_q, maj_q, maj_a_q, jpos, jneg;
  logic [1:0] svc_q;
  logic ring_q;
  tomj_slot_type sl;

  assign lclk = link.link_clk;
  assign d = link.link_data;

  tomj_sync #(.W(1)) u_ctl_sync (
    .clk_i(lclk),
    .srst_i(1'b0),
    .ce_i(1'b1),
    .d_i(ce_i),
    .q_o(ce_l)
  );

  // the link clock may stand still during reset, so reset is taken at once
  // and only its release is synchronised to the link clock
  always_ff @(posedge lclk or posedge srst_i) begin
    if (srst_i) begin
      rst_m_q <= 1'b1;
      rst_l_q <= 1'b1;
    end else begin
      rst_m_q <= 1'b0;
      rst_l_q <= rst_m_q;
    end
  end

  assign rst_l = rst_l_q;

  ////////////////////////////////////////////////////////////////////////
  // frame alignment
  assign match = ({sh_q[10:0], d} == FAW_WORD);
  assign at_faw = (set_q == SET_FAW) && (bit_q == FAW_LEN);
  assign wrap = (bit_q == SET_BITS) && (set_q == SET_JUST);
  assign lof_l = (st_q != st_sync);

  always_ff @(posedge lclk) begin
    if (rst_l) begin
      st_q <= st_search;
      cnt_q <= 2'h0;
      sh_q <= 12'h000;
      set_q <= SET_FAW;
      bit_q <= 10'h001;
    end else if (ce_l) begin
      sh_q <= {sh_q[10:0], d};
      if (bit_q == SET_BITS) begin
        bit_q <= 10'h001;
        set_q <= (set_q == SET_JUST) ? SET_FAW : set_q + 2'h1;
      end else begin
        bit_q <= bit_q + 10'h001;
      end
      case (st_q)
        st_search: begin
          if (match) begin
            // word seen anywhere: lock position, next bit is bit 13
            st_q <= st_verify;
            cnt_q <= 2'h1;
            set_q <= SET_FAW;
            bit_q <= FAW_LEN + 10'h001;
          end
        end
        st_verify: begin
          if (at_faw) begin
            if (!match) begin
              st_q <= st_search;
            end else if (cnt_q + 2'h1 == ALIGN_GAIN_CNT) begin
              st_q <= st_sync;
              cnt_q <= 2'h0;
            end else begin
              cnt_q <= cnt_q + 2'h1;
            end
          end
        end
        st_sync: begin
          if (at_faw) begin
            // one or two bad words keep the position
            if (match) cnt_q <= 2'h0;
            else if (cnt_q + 2'h1 == ALIGN_LOSS_CNT) st_q <= st_search;
            else cnt_q <= cnt_q + 2'h1;
          end
        end
        default: st_q <= st_search;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line loss (long zero run) and alarm signal (almost no zeros in a frame)
  assign los_l = (zrun_q == 8'(LOS_BITS));

  always_ff @(posedge lclk) begin
    if (rst_l) begin
      zrun_q <= 8'h00;
      zcnt_q <= 12'h000;
      ais_q <= 1'b0;
    end else if (ce_l) begin
      if (d) zrun_q <= 8'h00;
      else if (!los_l) zrun_q <= zrun_q + 8'h01;
      if (wrap) begin
        ais_q <= (zcnt_q + {11'h000, ~d}) <= AIS_MAX_ZEROS;
        zcnt_q <= 12'h000;
      end else if (!d && zcnt_q != 12'hfff) begin
        zcnt_q <= zcnt_q + 12'h001;
      end
    end
  end

  // received alarm signal sets no action of its own
  assign force_l = los_l | lof_l;
  assign prompt_l = los_l | (lof_l & ~ais_q);
  assign rai_l = los_l | lof_l;

  ////////////////////////////////////////////////////////////////////////
  // justification commands, pair phase and service bits
  assign sl = tomj_slot(set_q, bit_q);
  assign t = 2'(bit_q - 10'h001);
  assign jpos = maj_a_q & maj_q;
  assign jneg = ~maj_a_q & ~maj_q;

  always_ff @(posedge lclk) begin
    if (rst_l) begin
      c1_q <= 4'h0;
      c2_q <= 4'h0;
      maj_q <= 4'h0;
      maj_a_q <= 4'h0;
      pair_b_q <= 1'b0;
      svc_q <= 2'h0;
      ring_q <= 1'b0;
      rem_q <= 1'b0;
    end else if (ce_l) begin
      if (sl == sl_ctl && set_q == SET_SVC) begin
        if (bit_q <= CTL_HI) c1_q[t] <= d;
        else c2_q[t] <= d;
      end
      if (sl == sl_ctl && set_q == SET_JUST) maj_q[t] <= tomj_maj({c1_q[t], c2_q[t], d});
      if (sl == sl_svc) begin
        if (bit_q == SVC_A) svc_q[1] <= d;
        else svc_q[0] <= d;
      end
      if (sl == sl_ring) ring_q <= d;
      if (sl == sl_ralm) rem_q <= d & ~lof_l;
      if (wrap) begin
        maj_a_q <= maj_q;
        pair_b_q <= ~pair_b_q;
      end else if (set_q == SET_JUST && bit_q == SVC_A && pair_b_q && |(~maj_a_q & maj_q)) begin
        // 000 then 111 never occurs inside a pair: this frame opens one
        pair_b_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // tributary recovery, ones forced on line loss or misalignment
  always_comb begin
    case (sl)
      sl_data: keep = 1'b1;
      sl_neg: keep = pair_b_q & jneg[t];
      sl_pos: keep = ~(pair_b_q & jpos[t]);
      default: keep = 1'b0;
    endcase
  end

  always_ff @(posedge lclk) begin
    if (rst_l) begin
      trib_data_o <= 4'hf;
      trib_stb_o <= 4'h0;
      svc_data_o <= 2'h0;
      svc_ring_o <= 1'b0;
    end else if (ce_l) begin
      trib_stb_o <= keep ? (4'h1 << t) : 4'h0;
      if (keep) trib_data_o[t] <= d | force_l;
      if (force_l) trib_data_o <= 4'hf;
      if (wrap) begin
        svc_data_o <= svc_q;
        svc_ring_o <= ring_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarms into the system clock domain, levels only
  tomj_sync #(.W(5)) u_alm_sync (
    .clk_i(clk_sys_i),
    .srst_i(srst_i),
    .ce_i(ce_i),
    .d_i({prompt_l, rai_l, rem_q, lof_l, los_l}),
    .q_o({prompt_o, send_rai_o, rem_alarm_o, lof_o, los_o})
  );
endmodule
`default_nettype wire

// ### bench/tomj_props.sv
/*
  Checker for the composite link between the multiplexer and demultiplexer.
  Assumes the multiplexer starts on a frame boundary when reset is released.
*/
`timescale 1ns/10ps
`default_nettype none
module tomj_props
  import tomj_pkg::*;
#(
  parameter int DIV = LINK_DIV
) (
  input wire logic clk_sys_i,
  input wire logic srst_i,
  input wire logic ext_sel_i,
  input wire logic link_clk,
  input wire logic link_data
);
  //////////////////////////////////////////////////////////////////////////
  // frame tracker: locks once, so later alignment mimics in data are ignored
  logic [11:0] sh_q;
  logic [11:0] pos_q;
  logic run_q;
  logic odd_q;
  logic [3:0] ca_q;
  logic [3:0] cb_q;
  logic [1:0] t;
  logic [9:0] q;
  assign t = pos_q[1:0];
  assign q = run_q ? pos_q[11:2] : 10'h3ff;
  always_ff @(posedge link_clk) begin
    sh_q <= {sh_q[10:0], link_data};
    if (q == 10'h0b3) cb_q[t] <= link_data;
    if (!odd_q && pos_q == 12'h863) ca_q <= cb_q;
  end
  always_ff @(posedge link_clk or posedge srst_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
      odd_q <= 1'b0;
      pos_q <= 12'h000;
    end else if (!run_q && {sh_q[10:0], link_data} == FAW_WORD) begin
      run_q <= 1'b1;
      pos_q <= 12'h00c;
    end else if (run_q) begin
      pos_q <= (pos_q == 12'h863) ? 12'h000 : pos_q + 12'h001;
      odd_q <= (pos_q == 12'h863) ? ~odd_q : odd_q;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // divider watch; a switch back from the external source needs three edges
  logic lc_q;
  logic [7:0] cnt_q;
  logic [1:0] ok_q;
  always_ff @(posedge clk_sys_i) begin
    lc_q <= link_clk;
  end
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || ext_sel_i) begin
      cnt_q <= 8'h00;
      ok_q <= 2'h0;
    end else if (link_clk != lc_q) begin
      cnt_q <= 8'h00;
      ok_q <= (ok_q == 2'h3) ? ok_q : ok_q + 2'h1;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_edge;
    (link_clk != lc_q) && ok_q == 2'h3;
  endsequence
  sequence s_ctl_b;
    odd_q && q == 10'h0b3 && link_data;
  endsequence
  property p_faw;
    @(posedge link_clk) disable iff (srst_i) run_q && pos_q == 12'h00c |-> sh_q == FAW_WORD;
  endproperty
  a_faw: assert property (p_faw)
    else $error("alignment word wrong");
  property p_c2;
    @(posedge link_clk) disable iff (srst_i) q == 10'h0b5 |-> link_data == cb_q[t];
  endproperty
  a_c2: assert property (p_c2)
    else $error("second control bit differs");
  property p_c3;
    @(posedge link_clk) disable iff (srst_i) q == 10'h166 |-> link_data == cb_q[t];
  endproperty
  a_c3: assert property (p_c3)
    else $error("third control bit differs");
  property p_pair;
    @(posedge link_clk) disable iff (srst_i) s_ctl_b |-> ca_q[t];
  endproperty
  a_pair: assert property (p_pair)
    else $error("zeros then ones in one pair");
  property p_idle;
    @(posedge link_clk) disable iff (srst_i) odd_q && q == 10'h168 && ca_q[t] |-> link_data == cb_q[t];
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle negative slot wrong");
  property p_adv;
    @(posedge clk_sys_i) disable iff (srst_i) $changed(link_data) |-> $fell(link_clk);
  endproperty
  a_adv: assert property (p_adv)
    else $error("data moved off the falling link edge");
  property p_half;
    @(posedge clk_sys_i) disable iff (srst_i || ext_sel_i) s_edge |-> cnt_q == DIV / 2 - 1;
  endproperty
  a_half: assert property (p_half)
    else $error("link half period wrong");
  property p_max;
    @(posedge clk_sys_i) disable iff (srst_i || ext_sel_i) ok_q == 2'h3 |-> cnt_q < DIV / 2;
  endproperty
  a_max: assert property (p_max)
    else $error("link level held too long");
endmodule
`default_nettype wire

// ### bench/tb.sv
/*
  Testbench: multiplexer and demultiplexer on one link, plus a second
  demultiplexer fed by a bench driver with line faults.
  Assumes the design package, interface and modules are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  import tomj_pkg::*;
  localparam int DIV = 4;
  localparam int FRM = 2148 * DIV;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b0;
  logic rst2 = 1'b0;
  logic [3:0] trib_data = 4'h0;
  logic [3:0] trib_clk = 4'h0;
  logic [3:0] tclk_en = 4'hf;
  logic [3:0] trib_wig = 4'h0;
  logic [7:0] just_cmd = 8'h00;
  logic ext_clk = 1'b0;
  logic ext_sel = 1'b0;
  logic [1:0] svc_data = 2'h0;
  logic svc_ring = 1'b0;
  logic rem_alarm = 1'b0;
  logic [3:0] trib_los, rx_data, rx_stb, rx2_data, rx2_stb, exp_data;
  logic [1:0] rx_svc;
  logic mux_prompt, rx_ring, rx_prompt, rx_rai, rx_rem, rx_lof, rx_los;
  logic rx2_prompt, rx2_rai, rx2_lof, rx2_los;
  logic [31:0] lfsr = 32'h6a6a;
  logic chk_on = 1'b0;
  logic chk2_on = 1'b0;
  int num_errors = 0;
  int samples_checked = 0;
  int tdiv = 0;
  int ediv = 0;
  int n_ext = 0;
  int n_lnk = 0;
  tomj_link_if link();
  tomj_link_if link2();
  tomj_mux #(.DIV(DIV)) tomj_mux_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
    .link(link.mux_end), .trib_data_i(trib_data ^ trib_wig), .trib_clk_i(trib_clk),
    .just_cmd_i(just_cmd),
    .ext_clk_i(ext_clk), .ext_sel_i(ext_sel), .svc_data_i(svc_data), .svc_ring_i(svc_ring),
    .rem_alarm_i(rem_alarm), .trib_los_o(trib_los), .prompt_o(mux_prompt));
  tomj_demux tomj_demux_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(1'b1),
    .link(link.demux_end), .trib_data_o(rx_data), .trib_stb_o(rx_stb), .svc_data_o(rx_svc),
    .svc_ring_o(rx_ring), .prompt_o(rx_prompt), .send_rai_o(rx_rai), .rem_alarm_o(rx_rem),
    .lof_o(rx_lof), .los_o(rx_los));
  tomj_demux tomj_demux_fault_inst (.clk_sys_i(clk_sys_i), .srst_i(rst2), .ce_i(1'b1),
    .link(link2.demux_end), .trib_data_o(rx2_data), .trib_stb_o(rx2_stb), .svc_data_o(),
    .svc_ring_o(), .prompt_o(rx2_prompt), .send_rai_o(rx2_rai), .rem_alarm_o(),
    .lof_o(rx2_lof), .los_o(rx2_los));
  tomj_props #(.DIV(DIV)) tomj_props_inst (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .ext_sel_i(ext_sel), .link_clk(link.link_clk), .link_data(link.link_data));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // the bench link clock runs only while this task drives bits
  task automatic drive2(input logic v, input int n);
    repeat (n) begin
      #80 link2.link_clk = 1'b1;
      #80 link2.link_clk = 1'b0;
      link2.link_data = v;
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // tributary clocks 400 ns, below a quarter of the link rate; external 60 ns
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(negedge clk_sys_i) begin
    tdiv <= (tdiv + 1) % 20;
    ediv <= (ediv + 1) % 3;
    if (tdiv == 0) trib_clk <= trib_clk ^ tclk_en;
    // one-cycle data pulse far from the clock edge keeps live data circuits moving
    trib_wig <= (tdiv == 10) ? tclk_en : 4'h0;
    if (ediv == 0) ext_clk <= ~ext_clk;
  end
  always @(posedge ext_clk) if (ext_sel) n_ext++;
  always @(posedge link.link_clk) if (ext_sel) n_lnk++;
  // constant tributary levels make recovered bits independent of stuffing
  always @(negedge link.link_clk) begin
    if (chk_on && rx_stb != 4'h0) check({4'h0, rx_data & rx_stb}, {4'h0, exp_data & rx_stb});
  end
  always @(negedge link2.link_clk) begin
    if (chk2_on && rx2_stb != 4'h0) check({4'h0, rx2_data & rx2_stb}, {4'h0, rx2_stb});
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic phase(input int k, input logic [3:0] lost);
    lfsr = nxt(lfsr);
    @(negedge clk_sys_i);
    trib_data = lfsr[3:0] & ~lost;
    tclk_en = ~lost;
    for (int t = 0; t < 4; t++) just_cmd[2 * t +: 2] = 2'((k + t) % 3);
    svc_data = lfsr[5:4];
    svc_ring = lfsr[6];
    rem_alarm = lfsr[7] | (lost != 4'h0);
    exp_data = lfsr[3:0] | lost;
    repeat (FRM + FRM / 2) @(negedge clk_sys_i);
    chk_on = 1'b1;
    repeat (FRM) @(negedge clk_sys_i);
    chk_on = 1'b0;
    check({4'h0, trib_los}, {4'h0, lost});
    check({7'h0, mux_prompt}, {7'h0, lost != 4'h0});
    check({rx_svc, rx_ring, rx_rem, rx_prompt, rx_rai, rx_lof, rx_los}, {svc_data, svc_ring, rem_alarm, 4'h0});
    $display("phase %0d done", k);
  endtask
  initial begin
    int i;
    // raised after time zero so that edge-triggered resets see it
    #1 srst_i = 1'b1;
    repeat (20) @(negedge clk_sys_i);
    srst_i = 1'b0;
    repeat (100) @(negedge clk_sys_i);
    for (i = 100; i < 6 * FRM && rx_lof !== 1'b0; i++) @(negedge clk_sys_i);
    check({7'h0, rx_lof}, 8'h00);
    check({7'h0, i >= 2 * FRM}, 8'h01);
    $display("alignment done");
    phase(0, 4'h0);
    phase(1, 4'h0);
    phase(2, 4'h4);
    ext_sel = 1'b1;
    repeat (50) @(negedge clk_sys_i);
    n_ext = 0;
    n_lnk = 0;
    repeat (600) @(negedge clk_sys_i);
    check({7'h0, n_lnk > n_ext - 3 && n_lnk < n_ext + 3}, 8'h01);
    ext_sel = 1'b0;
    $display("external timing done");
    stop_test();
  end
  // line faults on the second link: all zeros, then an all-ones signal
  initial begin
    link2.link_clk = 1'b0;
    link2.link_data = 1'b0;
    #3 rst2 = 1'b1;
    drive2(1'b0, 8);
    @(negedge clk_sys_i) rst2 = 1'b0;
    drive2(1'b0, 100);
    chk2_on = 1'b1;
    drive2(1'b0, 100);
    check({4'h0, rx2_los, rx2_prompt, rx2_rai, rx2_lof}, 8'h0f);
    drive2(1'b1, 5000);
    check({4'h0, rx2_los, rx2_prompt, rx2_rai, rx2_lof}, 8'h03);
    chk2_on = 1'b0;
    $display("line fault done");
  end
  initial begin
    repeat (12 * FRM) @(posedge clk_sys_i);
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire
